// File: design/cei_top.sv
// Notes on behaviour
// R1 - Receive and transmit error counters kept and readable by software outside the start-up hold, which also clears both counters.
// R2 - Error-active while both counters stay below 128.
// R3 - Error-passive once either counter reaches 128 or more.
// R4 - Bus-off when transmit counter passes 255; held until recovery seen.
// R5 - Leave bus-off after 128 runs of 11 recessive bits, back to active.
// R6 - Warning flag set when either counter reaches 96, cleared below.
// R7 - Eight interrupt sources, each with enable bit and flag bit.
// R8 - Interrupt pin low while any enabled flag is set.
// R9 - Clearing a flag is ignored while its setting condition persists.
// R10 - Software should clear flags with the masked write, not plain writes.
// R11 - Software may set flags; an enabled one raises the interrupt.
// R12 - Interrupt code shows only enabled pending sources, next one after clear.
// R13 - Fixed code priority: none, error, wake, tx0-2, rx0-1.
// R14 - Transmit flag set when its buffer becomes empty.
// R15 - Receive flag set after end of frame of a stored message.
// R16 - Message error flag set on any transmit or receive error.
// R17 - Bus activity in sleep sets wake flag, exits to listen-only; the start-up hold that the wake starts clears the flag one cycle later.
// R18 - Error interrupt on receive overflow or any error state change.
// R19 - Overflow bit set when target buffer still full; software clears.
// R20 - Error flags: warnings, passive per side, bus-off.
// R21 - Logic held in reset 128 cycles after any reset or wake.
// R22 - Software waits out the start-up hold before any access.
// R23 - Counters follow the usual fault confinement steps.
`timescale 1ns/1ps
`include "cei_defs.svh"
module cei_top
(
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_bit_clk,
   input wire logic i_can_rx,
   input wire logic i_rx_err,
   input wire logic i_rx_err_sev,
   input wire logic i_tx_err,
   input wire logic i_rx_ok,
   input wire logic i_tx_ok,
   input wire logic [2:0] i_tx_empty,
   input wire logic [1:0] i_rx_loaded,
   input wire logic [1:0] i_rx_full,
   input wire logic [1:0] i_rx_overflow,
   output logic o_int_n,
   output logic o_core_hold,
   output logic o_sleep,
   output logic o_listen_only,
   output logic o_bus_off
);
   logic bit_clk_s1_r;
   logic bit_clk_s2_r;
   logic bit_clk_d_r;
   logic can_rx_s1_r;
   logic can_rx_s2_r;
   logic can_rx_d_r;
   logic [7:0] ost_cnt_r;
   logic ost_busy;
   logic core_rst_n;
   logic [7:0] irq_en_r;
   logic [7:0] irq_flag_r;
   logic [7:0] irq_flag_nxt;
   logic [1:0] ovr_r;
   logic [5:0] levels_d_r;
   logic sleep_r;
   logic listen_r;
   logic soft_rst_r;
   logic wake_evt;
   logic acc;
   logic wr_hit;
   logic [7:0] set_evt;
   logic [7:0] persist;
   logic [7:0] wr_mask;
   logic [7:0] wr_val;
   logic [7:0] pending;
   logic [2:0] irq_code;
   logic [7:0] err_flags;
   logic [31:0] rd_data;
   logic rd_ok;

   cei_cnt_if cnt_bus();

   // Pins from the bus side cross in through two flops each
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         bit_clk_s1_r <= 1'b0;
         bit_clk_s2_r <= 1'b0;
         bit_clk_d_r <= 1'b0;
         can_rx_s1_r <= 1'b1;
         can_rx_s2_r <= 1'b1;
         can_rx_d_r <= 1'b1;
      end
      else
      begin
         bit_clk_s1_r <= i_bit_clk;
         bit_clk_s2_r <= bit_clk_s1_r;
         bit_clk_d_r <= bit_clk_s2_r;
         can_rx_s1_r <= i_can_rx;
         can_rx_s2_r <= can_rx_s1_r;
         can_rx_d_r <= can_rx_s2_r;
      end
   end

   // Start-up hold, restarted by pin reset, soft reset and wake
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n || soft_rst_r || wake_evt)
         ost_cnt_r <= 8'h00; // R21
      else if (ost_cnt_r != `CEI_OST_CYCLES)
         ost_cnt_r <= ost_cnt_r + 8'h01; // R21
   end

   assign ost_busy = ost_cnt_r != `CEI_OST_CYCLES;
   assign core_rst_n = !ost_busy; // R21

   assign cnt_bus.rx_err = i_rx_err;
   assign cnt_bus.rx_err_sev = i_rx_err_sev;
   assign cnt_bus.tx_err = i_tx_err;
   assign cnt_bus.rx_ok = i_rx_ok;
   assign cnt_bus.tx_ok = i_tx_ok;
   assign cnt_bus.bit_tick = bit_clk_s2_r && !bit_clk_d_r;
   assign cnt_bus.bus_recessive = can_rx_s2_r;

   cei_err_counters u_counters
   (
      .i_clk(i_ref_clk),
      .i_rst_n(core_rst_n),
      .bus(cnt_bus.cnt)
   );

   // Falling edge on the receive line is bus activity
   assign wake_evt = sleep_r && core_rst_n && can_rx_d_r && !can_rx_s2_r; // R17

   // APB: every access answers one cycle after penable, none during the hold
   assign acc = i_psel && i_penable && o_pready;
   assign wr_hit = acc && i_pwrite;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end
      else
      begin
         o_pready <= i_psel && i_penable && !o_pready && !ost_busy; // R22
         // No error or data during the hold, so nothing shows without pready
         o_pslverr <= i_psel && i_penable && !o_pready && !ost_busy && !rd_ok;
         o_prdata <= (i_psel && i_penable && !o_pready && !ost_busy && !i_pwrite) ? rd_data
            : 32'h0000_0000;
      end
   end

   always_comb
   begin
      rd_ok = 1'b1;
      rd_data = 32'h0000_0000;
      case (i_paddr)
         `CEI_OFF_IRQ_EN: rd_data[7:0] = irq_en_r;
         `CEI_OFF_IRQ_FLAG: rd_data[7:0] = irq_flag_r;
         `CEI_OFF_MASKED_WR: rd_data[7:0] = irq_flag_r;
         `CEI_OFF_ERR_FLAG: rd_data[7:0] = err_flags;
         `CEI_OFF_TX_CNT: rd_data[8:0] = cnt_bus.tx_error_count; // R1
         `CEI_OFF_RX_CNT: rd_data[7:0] = cnt_bus.rx_error_count; // R1
         `CEI_OFF_STATUS: rd_data[7:0] = {cnt_bus.state, irq_code, listen_r, sleep_r};
         `CEI_OFF_CTRL: rd_data[7:0] = {5'h00, listen_r, 1'b0, sleep_r};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!core_rst_n)
         irq_en_r <= `CEI_RST_IRQ_EN;
      else if (wr_hit && i_paddr == `CEI_OFF_IRQ_EN)
         irq_en_r <= i_pwdata[7:0]; // R7
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!core_rst_n)
         soft_rst_r <= 1'b0;
      else
         soft_rst_r <= wr_hit && i_paddr == `CEI_OFF_CTRL && i_pwdata[`CEI_CB_SOFT_RST];
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n || soft_rst_r)
      begin
         sleep_r <= 1'b0;
         listen_r <= 1'b0;
      end
      else if (wake_evt)
      begin
         sleep_r <= 1'b0; // R17
         listen_r <= 1'b1; // R17
      end
      else if (wr_hit && i_paddr == `CEI_OFF_CTRL && core_rst_n)
      begin
         sleep_r <= i_pwdata[`CEI_CB_SLEEP];
         listen_r <= i_pwdata[`CEI_CB_LISTEN];
      end
   end

   // Overflow bits: set wins over a software clear in the same cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (!core_rst_n)
         ovr_r <= 2'b00;
      else if (wr_hit && i_paddr == `CEI_OFF_ERR_FLAG)
         ovr_r <= (ovr_r & i_pwdata[7:6]) | i_rx_overflow; // R19
      else
         ovr_r <= ovr_r | i_rx_overflow; // R19
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!core_rst_n)
         levels_d_r <= 6'h00;
      else
         levels_d_r <= cnt_bus.err_levels;
   end

   assign err_flags = {ovr_r, cnt_bus.err_levels}; // R20

   always_comb
   begin
      set_evt = 8'h00;
      set_evt[`CEI_FB_RX0] = i_rx_loaded[0]; // R15
      set_evt[`CEI_FB_RX1] = i_rx_loaded[1]; // R15
      set_evt[`CEI_FB_TX0] = i_tx_empty[0]; // R14
      set_evt[`CEI_FB_TX1] = i_tx_empty[1]; // R14
      set_evt[`CEI_FB_TX2] = i_tx_empty[2]; // R14
      set_evt[`CEI_FB_ERR] = (|i_rx_overflow) || (levels_d_r != cnt_bus.err_levels); // R18
      set_evt[`CEI_FB_WAKE] = wake_evt; // R17
      set_evt[`CEI_FB_MERR] = i_rx_err || i_rx_err_sev || i_tx_err; // R16
   end

   // Conditions still standing keep their flag against a clear
   always_comb
   begin
      persist = 8'h00;
      persist[`CEI_FB_RX0] = i_rx_full[0]; // R9
      persist[`CEI_FB_RX1] = i_rx_full[1]; // R9
      persist[`CEI_FB_TX0] = i_tx_empty[0]; // R9
      persist[`CEI_FB_TX1] = i_tx_empty[1]; // R9
      persist[`CEI_FB_TX2] = i_tx_empty[2]; // R9
      persist[`CEI_FB_ERR] = |ovr_r; // R9
   end

   // Plain write touches every bit; masked write only the mask bits
   always_comb
   begin
      wr_mask = 8'h00;
      wr_val = 8'h00;
      if (wr_hit && i_paddr == `CEI_OFF_IRQ_FLAG)
      begin
         wr_mask = 8'hFF;
         wr_val = i_pwdata[7:0];
      end
      else if (wr_hit && i_paddr == `CEI_OFF_MASKED_WR) // R10
      begin
         wr_mask = i_pwdata[15:8];
         wr_val = i_pwdata[7:0];
      end
      irq_flag_nxt = (irq_flag_r & ~wr_mask) | (wr_val & wr_mask); // R11
      irq_flag_nxt = irq_flag_nxt | set_evt | (irq_flag_r & persist); // R9
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!core_rst_n)
         irq_flag_r <= `CEI_RST_IRQ_FLAG;
      else
         irq_flag_r <= irq_flag_nxt; // R7
   end

   assign pending = irq_flag_r & irq_en_r; // R12

   cei_irq_prio u_prio
   (
      .i_clk(i_ref_clk),
      .i_rst_n(core_rst_n),
      .i_pending(pending),
      .o_code(irq_code)
   );

   always_ff @(posedge i_ref_clk)
   begin
      if (!core_rst_n)
      begin
         o_int_n <= 1'b1;
         o_bus_off <= 1'b0;
      end
      else
      begin
         o_int_n <= !(|pending); // R8
         o_bus_off <= cnt_bus.state == cei_pkg::CEI_ST_BUS_OFF; // R4
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_core_hold <= 1'b1;
         o_sleep <= 1'b0;
         o_listen_only <= 1'b0;
      end
      else
      begin
         o_core_hold <= ost_busy;
         o_sleep <= sleep_r;
         o_listen_only <= listen_r;
      end
   end
endmodule

// File: design/cei_defs.svh
`ifndef CEI_DEFS_SVH
`define CEI_DEFS_SVH

// Register byte offsets
`define CEI_OFF_IRQ_EN 8'h00
`define CEI_OFF_IRQ_FLAG 8'h04
`define CEI_OFF_MASKED_WR 8'h08
`define CEI_OFF_ERR_FLAG 8'h0C
`define CEI_OFF_TX_CNT 8'h10
`define CEI_OFF_RX_CNT 8'h14
`define CEI_OFF_STATUS 8'h18
`define CEI_OFF_CTRL 8'h1C

// Interrupt flag bit positions
`define CEI_FB_RX0 0
`define CEI_FB_RX1 1
`define CEI_FB_TX0 2
`define CEI_FB_TX1 3
`define CEI_FB_TX2 4
`define CEI_FB_ERR 5
`define CEI_FB_WAKE 6
`define CEI_FB_MERR 7

// Error flag bit positions
`define CEI_EB_WARN 0
`define CEI_EB_RX_WARN 1
`define CEI_EB_TX_WARN 2
`define CEI_EB_RX_PASSIVE 3
`define CEI_EB_TX_PASSIVE 4
`define CEI_EB_BUS_OFF 5
`define CEI_EB_RX0_OVR 6
`define CEI_EB_RX1_OVR 7

// Control bit positions
`define CEI_CB_SLEEP 0
`define CEI_CB_SOFT_RST 1
`define CEI_CB_LISTEN 2

// Reset values
`define CEI_RST_IRQ_EN 8'h00
`define CEI_RST_IRQ_FLAG 8'h00

// Counter limits
`define CEI_WARN_LIMIT 9'h060
`define CEI_PASSIVE_LIMIT 9'h080
`define CEI_BUSOFF_LIMIT 9'h0FF
`define CEI_REC_RESUME 8'h78
`define CEI_TX_ERR_STEP 9'h008
`define CEI_RX_SEV_STEP 8'h08

// Timing counts
`define CEI_RECOV_BITS 4'hB
`define CEI_RECOV_RUNS 8'h80
`define CEI_OST_CYCLES 8'h80

`endif

// File: design/cei_pkg.sv
package cei_pkg;

   typedef enum logic [2:0]
   {
      CEI_ST_ACTIVE = 3'b001,
      CEI_ST_PASSIVE = 3'b010,
      CEI_ST_BUS_OFF = 3'b100
   } cei_err_state_e;

endpackage

// File: design/cei_cnt_if.sv
`timescale 1ns/1ps
interface cei_cnt_if;
   logic rx_err;
   logic rx_err_sev;
   logic tx_err;
   logic rx_ok;
   logic tx_ok;
   logic bit_tick;
   logic bus_recessive;
   logic [7:0] rx_error_count;
   logic [8:0] tx_error_count;
   logic [5:0] err_levels;
   cei_pkg::cei_err_state_e state;

   modport core
   (
      output rx_err, rx_err_sev, tx_err, rx_ok, tx_ok, bit_tick, bus_recessive,
      input rx_error_count, tx_error_count, err_levels, state
   );
   modport cnt
   (
      input rx_err, rx_err_sev, tx_err, rx_ok, tx_ok, bit_tick, bus_recessive,
      output rx_error_count, tx_error_count, err_levels, state
   );
endinterface

// File: design/cei_err_counters.sv
`timescale 1ns/1ps
`include "cei_defs.svh"
module cei_err_counters
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   cei_cnt_if.cnt bus
);
   logic [7:0] rec_r;
   logic [8:0] tec_r;
   logic [3:0] ones_r;
   logic [7:0] runs_r;
   logic recovered;
   cei_pkg::cei_err_state_e state_r;

   assign recovered = bus.bit_tick && bus.bus_recessive && ones_r == `CEI_RECOV_BITS - 4'h1
      && runs_r == `CEI_RECOV_RUNS - 8'h01;

   // Recovery sequence: runs of recessive bits seen only while bus-off
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || state_r != cei_pkg::CEI_ST_BUS_OFF)
      begin
         ones_r <= 4'h0;
         runs_r <= 8'h00;
      end
      else if (bus.bit_tick)
      begin
         if (!bus.bus_recessive)
            ones_r <= 4'h0;
         else if (ones_r == `CEI_RECOV_BITS - 4'h1) // R5
         begin
            ones_r <= 4'h0;
            runs_r <= runs_r + 8'h01;
         end
         else
            ones_r <= ones_r + 4'h1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || recovered)
         tec_r <= 9'h000;
      else if (state_r == cei_pkg::CEI_ST_BUS_OFF)
         tec_r <= tec_r;
      else if (bus.tx_err) // R23
         tec_r <= (tec_r > 9'h1FF - `CEI_TX_ERR_STEP) ? 9'h1FF : tec_r + `CEI_TX_ERR_STEP;
      else if (bus.tx_ok && tec_r != 9'h000) // R23
         tec_r <= tec_r - 9'h001;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || recovered)
         rec_r <= 8'h00;
      else if (state_r == cei_pkg::CEI_ST_BUS_OFF)
         rec_r <= rec_r;
      else if (bus.rx_err_sev) // R23
         rec_r <= (rec_r > 8'hFF - `CEI_RX_SEV_STEP) ? 8'hFF : rec_r + `CEI_RX_SEV_STEP;
      else if (bus.rx_err && rec_r != 8'hFF) // R23
         rec_r <= rec_r + 8'h01;
      else if (bus.rx_ok && {1'b0, rec_r} >= `CEI_PASSIVE_LIMIT) // R23
         rec_r <= `CEI_REC_RESUME;
      else if (bus.rx_ok && rec_r != 8'h00)
         rec_r <= rec_r - 8'h01;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         state_r <= cei_pkg::CEI_ST_ACTIVE;
      else
      begin
         case (state_r)
            cei_pkg::CEI_ST_ACTIVE, cei_pkg::CEI_ST_PASSIVE:
               if (tec_r > `CEI_BUSOFF_LIMIT) // R4
                  state_r <= cei_pkg::CEI_ST_BUS_OFF;
               else if (tec_r >= `CEI_PASSIVE_LIMIT || {1'b0, rec_r} >= `CEI_PASSIVE_LIMIT) // R3
                  state_r <= cei_pkg::CEI_ST_PASSIVE;
               else // R2
                  state_r <= cei_pkg::CEI_ST_ACTIVE;
            cei_pkg::CEI_ST_BUS_OFF:
               if (recovered) // R5
                  state_r <= cei_pkg::CEI_ST_ACTIVE;
            default:
               state_r <= cei_pkg::CEI_ST_ACTIVE;
         endcase
      end
   end

   assign bus.rx_error_count = rec_r;
   assign bus.tx_error_count = tec_r;
   assign bus.state = state_r;
   assign bus.err_levels[`CEI_EB_RX_WARN] = {1'b0, rec_r} >= `CEI_WARN_LIMIT; // R20
   assign bus.err_levels[`CEI_EB_TX_WARN] = tec_r >= `CEI_WARN_LIMIT; // R20
   assign bus.err_levels[`CEI_EB_WARN] = {1'b0, rec_r} >= `CEI_WARN_LIMIT
      || tec_r >= `CEI_WARN_LIMIT; // R6
   assign bus.err_levels[`CEI_EB_RX_PASSIVE] = {1'b0, rec_r} >= `CEI_PASSIVE_LIMIT; // R20
   assign bus.err_levels[`CEI_EB_TX_PASSIVE] = tec_r >= `CEI_PASSIVE_LIMIT; // R20
   assign bus.err_levels[`CEI_EB_BUS_OFF] = state_r == cei_pkg::CEI_ST_BUS_OFF; // R20
endmodule

// File: design/cei_irq_prio.sv
`timescale 1ns/1ps
`include "cei_defs.svh"
module cei_irq_prio
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_pending,
   output logic [2:0] o_code
);
   logic [2:0] code_nxt;

   // Lower code wins; message error has no code of its own
   always_comb
   begin
      code_nxt = 3'h0;
      if (i_pending[`CEI_FB_ERR]) // R13
         code_nxt = 3'h1;
      else if (i_pending[`CEI_FB_WAKE])
         code_nxt = 3'h2;
      else if (i_pending[`CEI_FB_TX0])
         code_nxt = 3'h3;
      else if (i_pending[`CEI_FB_TX1])
         code_nxt = 3'h4;
      else if (i_pending[`CEI_FB_TX2])
         code_nxt = 3'h5;
      else if (i_pending[`CEI_FB_RX0])
         code_nxt = 3'h6;
      else if (i_pending[`CEI_FB_RX1])
         code_nxt = 3'h7;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_code <= 3'h0;
      else
         o_code <= code_nxt; // R12
   end
endmodule

// File: test/cei_top_chk.sv
`timescale 1ns/1ps
module cei_top_chk
(
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [7:0] i_paddr,
   input wire logic i_bit_clk,
   input wire logic i_can_rx,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_int_n,
   input wire logic o_core_hold,
   input wire logic o_sleep,
   input wire logic o_listen_only,
   input wire logic o_bus_off
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   logic [7:0] hold_cnt_r;
   logic [11:0] tick_cnt_r;
   logic [2:0] bclk_r;
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n || !o_core_hold)
         hold_cnt_r <= 8'h00;
      else if (hold_cnt_r != 8'hFF)
         hold_cnt_r <= hold_cnt_r + 8'h01;
   end
   // Own synchroniser of the same depth; sees each tick in the same cycle as the design
   always_ff @(posedge i_ref_clk)
   begin
      bclk_r <= {bclk_r[1:0], i_bit_clk};
      if (!i_reset_n || !o_bus_off)
         tick_cnt_r <= 12'h000;
      else if (bclk_r[1] && !bclk_r[2] && tick_cnt_r != 12'hFFF)
         tick_cnt_r <= tick_cnt_r + 12'h001;
   end
   sequence s_wake;
      o_sleep && $fell(i_can_rx);
   endsequence
   sequence s_listen;
      !o_sleep && o_listen_only && o_core_hold;
   endsequence
   ready_pulse_a: assert property (o_pready |=> !o_pready)
      else $error("ready longer than one cycle");
   ready_wait_a: assert property (i_psel && i_penable && !o_pready && !o_core_hold |=> o_pready)
      else $error("ready not one cycle after access");
   slverr_map_a: assert property (o_pready |->
      o_pslverr == (i_paddr > 8'h1C || i_paddr[1:0] != 2'h0))
      else $error("error response mismatch");
   rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
      else $error("read data outside answer");
   hold_quiet_a: assert property (o_core_hold && $past(o_core_hold, 3) |-> o_int_n && !o_pready)
      else $error("activity during hold");
   hold_len_a: assert property ($fell(o_core_hold) |-> hold_cnt_r inside {[8'h7E:8'h83]})
      else $error("hold length wrong");
   busoff_exit_a: assert property ($fell(o_bus_off) |-> tick_cnt_r >= 12'h57F)
      else $error("bus-off left early");
   wake_exit_a: assert property (s_wake |-> ##[1:6] s_listen)
      else $error("no wake into listen");
endmodule
bind cei_top cei_top_chk u_chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
   .i_penable(i_penable), .i_paddr(i_paddr), .i_bit_clk(i_bit_clk), .i_can_rx(i_can_rx),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_int_n(o_int_n),
   .o_core_hold(o_core_hold), .o_sleep(o_sleep), .o_listen_only(o_listen_only),
   .o_bus_off(o_bus_off));

// File: test/cei_can_bus_model.sv
`timescale 1ns/1ps
module cei_can_bus_model
(
   input wire logic i_run,
   input wire logic i_dominant,
   output logic o_bit_clk,
   output logic o_can_rx
);
   // Bus bias pulls the idle line recessive
   assign o_can_rx = !i_dominant;
   initial
   begin
      o_bit_clk = 1'b0;
      #3.1;
      // Stands low between frames; each toggle falls 0.9 ns before a core clock rising edge
      forever #40 o_bit_clk = i_run ? !o_bit_clk : 1'b0;
   end
endmodule

// File: test/tb_cei_top.sv
`timescale 1ns/1ps
`include "cei_defs.svh"
module tb_cei_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic pready, pslverr, err, int_n, hold, sleep, listen, bus_off, bclk, can_rx;
   logic run = 1'b0;
   logic dom = 1'b0;
   logic [2:0] tx_empty = 3'h0;
   logic [1:0] rx_full = 2'h0;
   logic [8:0] ev = 9'h000;
   logic [7:0] v, e;
   integer seed = 32'hAC1243B0;
   int mismatches = 0;
   int total_checks = 0;
   int i;
   always #4 clk = !clk;
   cei_top dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_bit_clk(bclk), .i_can_rx(can_rx),
      .i_rx_err(ev[0]), .i_rx_err_sev(ev[1]), .i_tx_err(ev[2]), .i_rx_ok(ev[3]),
      .i_tx_ok(ev[4]), .i_tx_empty(tx_empty), .i_rx_loaded(ev[6:5]), .i_rx_full(rx_full),
      .i_rx_overflow(ev[8:7]), .o_int_n(int_n), .o_core_hold(hold), .o_sleep(sleep),
      .o_listen_only(listen), .o_bus_off(bus_off));
   cei_can_bus_model bus (.i_run(run), .i_dominant(dom), .o_bit_clk(bclk), .o_can_rx(can_rx));
   function logic [2:0] code_of(input logic [7:0] p);
      code_of = p[5] ? 3'h1 : p[6] ? 3'h2 : p[2] ? 3'h3 : p[3] ? 3'h4 :
         p[4] ? 3'h5 : p[0] ? 3'h6 : p[1] ? 3'h7 : 3'h0;
   endfunction
   task complete_run;
      $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task guard(input logic ok);
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, ok, 1'b1);
         complete_run;
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && n++ < 40);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      guard(pready);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task pulse(input int b, input int n);
      repeat (n)
      begin
         @(posedge clk);
         ev <= 9'h001 << b;
      end
      @(posedge clk);
      ev <= 9'h000;
   endtask
   // Accesses must wait out the start-up hold
   task wait_hold;
      for (i = 0; i < 300 && hold !== 1'b0; i++)
         @(posedge clk);
      guard(!hold);
      repeat (4) @(posedge clk);
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      wait_hold;
      rd(`CEI_OFF_IRQ_EN, 32'h0);
      rd(`CEI_OFF_STATUS, 32'h20);
      rd(`CEI_OFF_TX_CNT, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      for (i = 0; i < 24; i++)
      begin
         v = (i < 8) ? 8'h01 << i : 8'($random(seed));
         e = (i < 8) ? 8'hFF : 8'($random(seed));
         apb(1'b1, `CEI_OFF_IRQ_EN, {24'h0, e});
         apb(1'b1, `CEI_OFF_IRQ_FLAG, {24'h0, v});
         rd(`CEI_OFF_STATUS, {24'h0, 3'h1, code_of(v & e), 2'h0});
         chk(int_n, !(|(v & e)));
         apb(1'b1, `CEI_OFF_MASKED_WR, 32'h2000);
         rd(`CEI_OFF_IRQ_FLAG, {24'h0, v & 8'hDF});
         rd(`CEI_OFF_STATUS, {24'h0, 3'h1, code_of(v & e & 8'hDF), 2'h0});
      end
      apb(1'b1, `CEI_OFF_IRQ_FLAG, 32'h0);
      apb(1'b1, `CEI_OFF_IRQ_EN, 32'h04);
      tx_empty <= 3'h1;
      rx_full <= 2'h2;
      pulse(6, 1);
      apb(1'b1, `CEI_OFF_MASKED_WR, 32'h0600);
      rd(`CEI_OFF_IRQ_FLAG, 32'h06);
      chk(int_n, 1'b0);
      tx_empty <= 3'h0;
      rx_full <= 2'h0;
      apb(1'b1, `CEI_OFF_MASKED_WR, 32'h0600);
      rd(`CEI_OFF_IRQ_FLAG, 32'h0);
      chk(int_n, 1'b1);
      pulse(0, 1);
      pulse(1, 1);
      pulse(3, 1);
      rd(`CEI_OFF_RX_CNT, 32'h08);
      rd(`CEI_OFF_IRQ_FLAG, 32'h80);
      pulse(2, 12);
      rd(`CEI_OFF_ERR_FLAG, 32'h05);
      rd(`CEI_OFF_IRQ_FLAG, 32'hA0);
      pulse(4, 1);
      rd(`CEI_OFF_TX_CNT, 32'h5F);
      rd(`CEI_OFF_ERR_FLAG, 32'h0);
      pulse(2, 5);
      rd(`CEI_OFF_ERR_FLAG, 32'h15);
      rd(`CEI_OFF_STATUS, 32'h40);
      pulse(2, 16);
      rd(`CEI_OFF_TX_CNT, 32'h107);
      rd(`CEI_OFF_STATUS, 32'h80);
      rd(`CEI_OFF_ERR_FLAG, 32'h35);
      run <= 1'b1;
      for (i = 0; i < 20000 && bus_off !== 1'b0; i++)
         @(posedge clk);
      guard(!bus_off);
      chk(i > 14000, 1'b1);
      run <= 1'b0;
      rd(`CEI_OFF_STATUS, 32'h20);
      apb(1'b1, `CEI_OFF_IRQ_FLAG, 32'h0);
      pulse(7, 1);
      rd(`CEI_OFF_ERR_FLAG, 32'h40);
      apb(1'b1, `CEI_OFF_MASKED_WR, 32'h2000);
      rd(`CEI_OFF_IRQ_FLAG, 32'h20);
      apb(1'b1, `CEI_OFF_ERR_FLAG, 32'h0);
      apb(1'b1, `CEI_OFF_MASKED_WR, 32'h2000);
      rd(`CEI_OFF_ERR_FLAG, 32'h0);
      rd(`CEI_OFF_IRQ_FLAG, 32'h0);
      apb(1'b1, `CEI_OFF_CTRL, 32'h1);
      // Sleep output lags the write edge by one register
      repeat (2) @(posedge clk);
      chk(sleep, 1'b1);
      dom <= 1'b1;
      for (i = 0; i < 10 && listen !== 1'b1; i++)
         @(posedge clk);
      guard(listen);
      chk(sleep, 1'b0);
      chk(hold, 1'b1);
      dom <= 1'b0;
      wait_hold;
      rd(`CEI_OFF_STATUS, 32'h22);
      rd(`CEI_OFF_IRQ_EN, 32'h0);
      apb(1'b1, `CEI_OFF_IRQ_EN, 32'hFF);
      apb(1'b1, `CEI_OFF_CTRL, 32'h4);
      rd(`CEI_OFF_CTRL, 32'h4);
      apb(1'b1, `CEI_OFF_CTRL, 32'h6);
      // Soft reset reaches the hold output two edges after the write
      repeat (3) @(posedge clk);
      chk(hold, 1'b1);
      wait_hold;
      rd(`CEI_OFF_STATUS, 32'h20);
      rd(`CEI_OFF_IRQ_EN, 32'h0);
      complete_run;
   end
endmodule
